// ===== verilog/msl_pkg.sv
// Constants, register map and shared types of the monitor sequencer core.
// Assumes a single 40 MHz clock domain; every module but msl_pin_sync refers here by name.
package msl_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_MAX_MS = 35;
  localparam int TIMEOUT_TICKS = TIMEOUT_MS * 1000 / TICK_US + 1;
  localparam int LP_PERIOD_MS = 728;
  localparam int LP_TICKS = LP_PERIOD_MS * 1000 / TICK_US;

  localparam int RES_W = 12;
  localparam int TEMP_W = 9;
  localparam int NCH = 8;
  localparam int TEMP_CH = 7;

  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_INT_STATUS = 8'h01;
  localparam logic [7:0] REG_INT_MASK = 8'h03;
  localparam logic [7:0] REG_CONV_RATE = 8'h07;
  localparam logic [7:0] REG_CH_DISABLE = 8'h08;
  localparam logic [7:0] REG_ADV_CONFIG = 8'h0b;
  localparam logic [7:0] REG_BUSY_STATUS = 8'h0c;
  localparam logic [7:0] REG_RESULT_BASE = 8'h20;
  localparam logic [7:0] REG_LIMIT_BASE = 8'h2a;
  localparam logic [7:0] REG_LIMIT_LAST = 8'h39;

  localparam int CFG_START_BIT = 0;
  localparam int CFG_INT_EN_BIT = 1;
  localparam int RATE_CONT_BIT = 0;
  localparam int ADV_EXT_REF_BIT = 0;

  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] DISABLE_RST = 8'h00;
  localparam logic [7:0] ADV_RST = 8'h00;
  localparam logic [7:0] LIM_HI_RST = 8'hff;
  localparam logic [7:0] LIM_LO_RST = 8'h00;
  localparam logic [7:0] TEMP_HI_RST = 8'h7f;
  localparam logic [7:0] TEMP_LO_RST = 8'h80;

  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [6:0] ADDR_BASE_LOW = 7'h1d;
  localparam logic [6:0] ADDR_BASE_MID = 7'h2d;
  localparam logic [6:0] ADDR_BASE_HIGH = 7'h35;

  typedef struct packed {
    logic start;
    logic [2:0] chan;
  } msl_conv_req_t;

  typedef struct packed {
    logic done;
    logic [RES_W-1:0] data;
  } msl_conv_rsp_t;

  typedef enum logic [3:0] {
    I2C_IDLE = 4'h0,
    I2C_ADDR = 4'h1,
    I2C_ADDR_ACK = 4'h3,
    I2C_PTR = 4'h2,
    I2C_PTR_ACK = 4'h6,
    I2C_WDATA = 4'h7,
    I2C_WDATA_ACK = 4'h5,
    I2C_READ = 4'h4,
    I2C_READ_ACK = 4'hc
  } msl_i2c_state_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_START = 3'h1,
    SEQ_WAIT = 3'h3,
    SEQ_CMP = 3'h2,
    SEQ_NEXT = 3'h6,
    SEQ_PAUSE = 3'h7
  } msl_seq_state_t;

endpackage : msl_pkg

// ===== verilog/msl_pin_sync.sv
// Three-stage synchroniser for pins from outside the clock domain.
// A new level is passed on only once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module msl_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        s1_q[i] <= RST[i];
        s2_q[i] <= RST[i];
        s3_q[i] <= RST[i];
        out_q[i] <= RST[i];
      end else begin
        s1_q[i] <= din[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign dout = out_q;

endmodule : msl_pin_sync
`default_nettype wire

// ===== verilog/msl_core.sv
// Digital core of an eight-channel monitor: two-wire slave, register file,
// round-robin sequencer with limit checks and an active-low alert output.
// Assumes the converter answers on the same clock; bus pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module msl_core #(
  parameter int TICK_CYCLES = msl_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_select_low,
  input wire logic [1:0] addr_select_high,
  output msl_pkg::msl_conv_req_t conv_req,
  input wire msl_pkg::msl_conv_rsp_t conv_rsp,
  output logic ext_ref_sel,
  output logic int_n
);

  // Pin synchronisation and bus edges
  logic [5:0] pins_s;
  logic scl_s, sda_s, scl_p_q, sda_p_q;
  logic [1:0] a0_s, a1_s;

  msl_pin_sync #(.W(6), .RST(6'h03)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({addr_select_high, addr_select_low, scl_in, sda_in}),
    .dout(pins_s)
  );

  assign {a1_s, a0_s, scl_s, sda_s} = pins_s;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Sampling at 40 MHz leaves ample margin at either bus rate
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_det = scl_s & scl_p_q & ~sda_s & sda_p_q;
  wire stop_det = scl_s & scl_p_q & sda_s & ~sda_p_q;

  // Slave address from the two three-level pins
  wire [6:0] addr_base = (a1_s == msl_pkg::LVL_LOW) ? msl_pkg::ADDR_BASE_LOW :
                         (a1_s == msl_pkg::LVL_MID) ? msl_pkg::ADDR_BASE_MID : msl_pkg::ADDR_BASE_HIGH;
  wire [6:0] addr_ofs = (a0_s == msl_pkg::LVL_LOW) ? 7'h0 : (a0_s == msl_pkg::LVL_MID) ? 7'h1 : 7'h2;
  wire [6:0] my_addr = addr_base + addr_ofs;

  // Millisecond tick and bus timeout
  logic [15:0] tick_cnt_q;
  logic [4:0] to_cnt_q;
  wire tick = tick_cnt_q == 16'(TICK_CYCLES - 1);
  wire line_low = ~scl_s | ~sda_s;
  // Counts whole ticks, so a reset fires after 25 to 26 ms of low level
  wire bus_reset = to_cnt_q == 5'(msl_pkg::TIMEOUT_TICKS);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_q <= 16'h0000;
      to_cnt_q <= 5'h00;
    end else begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      if (!line_low) begin
        to_cnt_q <= 5'h00;
      end else if (tick && !bus_reset) begin
        to_cnt_q <= to_cnt_q + 5'h01;
      end
    end
  end

  // Register file storage
  logic [7:0] cfg_q, mask_q, rate_q, dis_q, adv_q, stat_q;
  logic [7:0] lim_hi_q [msl_pkg::NCH];
  logic [7:0] lim_lo_q [msl_pkg::NCH];
  logic [msl_pkg::RES_W-1:0] res_q [msl_pkg::NCH];
  logic [7:0] res_hi [msl_pkg::NCH];
  logic [7:0] res_lo [msl_pkg::NCH];
  msl_pkg::msl_seq_state_t seq_q;

  // Two-wire slave
  msl_pkg::msl_i2c_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
  logic rw_q, rw_d, lo_q, lo_d, ackm_q, ackm_d, wr_en, stat_clr;

  wire is_res = ptr_q[7:3] == msl_pkg::REG_RESULT_BASE[7:3];
  wire is_lim = (ptr_q >= msl_pkg::REG_LIMIT_BASE) && (ptr_q <= msl_pkg::REG_LIMIT_LAST);
  wire [7:0] lim_sel = ptr_q - msl_pkg::REG_LIMIT_BASE;
  wire [7:0] lim_byte = lim_sel[0] ? lim_lo_q[lim_sel[3:1]] : lim_hi_q[lim_sel[3:1]];
  wire [7:0] busy_byte = {7'h00, seq_q != msl_pkg::SEQ_IDLE};
  wire [7:0] rd_hi = is_res ? res_hi[ptr_q[2:0]] :
                     is_lim ? lim_byte :
                     (ptr_q == msl_pkg::REG_CONFIG) ? cfg_q :
                     (ptr_q == msl_pkg::REG_INT_STATUS) ? stat_q :
                     (ptr_q == msl_pkg::REG_INT_MASK) ? mask_q :
                     (ptr_q == msl_pkg::REG_CONV_RATE) ? rate_q :
                     (ptr_q == msl_pkg::REG_CH_DISABLE) ? dis_q :
                     (ptr_q == msl_pkg::REG_ADV_CONFIG) ? adv_q :
                     (ptr_q == msl_pkg::REG_BUSY_STATUS) ? busy_byte : 8'h00;
  wire [7:0] rd_lo = res_lo[ptr_q[2:0]];
  wire ptr_is_stat = ptr_q == msl_pkg::REG_INT_STATUS;

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    lo_d = lo_q;
    ackm_d = ackm_q;
    wr_en = 1'b0;
    stat_clr = 1'b0;
    if (bus_reset || stop_det) begin
      st_d = msl_pkg::I2C_IDLE;
    end else if (start_det) begin
      st_d = msl_pkg::I2C_ADDR;
      bit_d = 4'h0;
    end else if (scl_rise) begin
      if (st_q inside {msl_pkg::I2C_ADDR, msl_pkg::I2C_PTR, msl_pkg::I2C_WDATA}) begin
        sh_d = {sh_q[6:0], sda_s};
        bit_d = bit_q + 4'h1;
      end else if (st_q == msl_pkg::I2C_READ) begin
        bit_d = bit_q + 4'h1;
      end else if (st_q == msl_pkg::I2C_READ_ACK) begin
        ackm_d = ~sda_s;
      end
    end else if (scl_fall) begin
      unique case (st_q)
        msl_pkg::I2C_IDLE: ;
        msl_pkg::I2C_ADDR: if (bit_q == 4'h8) begin
          bit_d = 4'h0;
          rw_d = sh_q[0];
          st_d = (sh_q[7:1] == my_addr) ? msl_pkg::I2C_ADDR_ACK : msl_pkg::I2C_IDLE;
        end
        msl_pkg::I2C_PTR: if (bit_q == 4'h8) begin
          bit_d = 4'h0;
          ptr_d = sh_q;
          st_d = msl_pkg::I2C_PTR_ACK;
        end
        msl_pkg::I2C_WDATA: if (bit_q == 4'h8) begin
          bit_d = 4'h0;
          wr_en = 1'b1;
          st_d = msl_pkg::I2C_WDATA_ACK;
        end
        msl_pkg::I2C_ADDR_ACK: begin
          if (rw_q) begin
            st_d = msl_pkg::I2C_READ;
            tx_d = rd_hi;
            lo_d = 1'b0;
            stat_clr = ptr_is_stat;
          end else begin
            st_d = msl_pkg::I2C_PTR;
          end
        end
        msl_pkg::I2C_PTR_ACK, msl_pkg::I2C_WDATA_ACK: st_d = msl_pkg::I2C_WDATA;
        msl_pkg::I2C_READ: begin
          if (bit_q == 4'h8) begin
            bit_d = 4'h0;
            st_d = msl_pkg::I2C_READ_ACK;
          end else begin
            tx_d = {tx_q[6:0], 1'b0};
          end
        end
        msl_pkg::I2C_READ_ACK: begin
          if (!ackm_q) begin
            st_d = msl_pkg::I2C_IDLE;
          end else if (is_res && !lo_q) begin
            st_d = msl_pkg::I2C_READ;
            tx_d = rd_lo;
            lo_d = 1'b1;
          end else begin
            st_d = msl_pkg::I2C_READ;
            tx_d = rd_hi;
            lo_d = 1'b0;
            stat_clr = ptr_is_stat;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= msl_pkg::I2C_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'hff;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      lo_q <= 1'b0;
      ackm_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      lo_q <= lo_d;
      ackm_q <= ackm_d;
    end
  end

  // Open-drain data line: only ever pulled low
  wire ack_drive = st_q inside {msl_pkg::I2C_ADDR_ACK, msl_pkg::I2C_PTR_ACK, msl_pkg::I2C_WDATA_ACK};
  assign sda_out = 1'b0;
  assign sda_oe = ack_drive | ((st_q == msl_pkg::I2C_READ) & ~tx_q[7]);

  // Plain registers
  wire wr_cfg = wr_en && (ptr_q == msl_pkg::REG_CONFIG);
  wire wr_mask = wr_en && (ptr_q == msl_pkg::REG_INT_MASK);
  wire wr_rate = wr_en && (ptr_q == msl_pkg::REG_CONV_RATE);
  wire wr_dis = wr_en && (ptr_q == msl_pkg::REG_CH_DISABLE);
  wire wr_adv = wr_en && (ptr_q == msl_pkg::REG_ADV_CONFIG);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= msl_pkg::CONFIG_RST;
      mask_q <= msl_pkg::MASK_RST;
      rate_q <= msl_pkg::RATE_RST;
      dis_q <= msl_pkg::DISABLE_RST;
      adv_q <= msl_pkg::ADV_RST;
    end else begin
      if (wr_cfg) cfg_q <= sh_q;
      if (wr_mask) mask_q <= sh_q;
      if (wr_rate) rate_q <= sh_q;
      if (wr_dis) dis_q <= sh_q;
      if (wr_adv) adv_q <= sh_q;
    end
  end

  assign ext_ref_sel = adv_q[msl_pkg::ADV_EXT_REF_BIT];

  // Sequencer
  logic [2:0] ch_q;
  logic [9:0] lp_cnt_q;
  logic conv_start_q;
  wire run = cfg_q[msl_pkg::CFG_START_BIT];
  wire last_ch = ch_q == 3'(msl_pkg::NCH - 1);
  wire lp_done = lp_cnt_q == 10'(msl_pkg::LP_TICKS - 1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_q <= msl_pkg::SEQ_IDLE;
      ch_q <= 3'h0;
      lp_cnt_q <= 10'h000;
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      unique case (seq_q)
        msl_pkg::SEQ_IDLE: if (run) begin
          ch_q <= 3'h0;
          seq_q <= msl_pkg::SEQ_START;
        end
        msl_pkg::SEQ_START: begin
          if (dis_q[ch_q]) begin
            seq_q <= msl_pkg::SEQ_NEXT;
          end else begin
            conv_start_q <= 1'b1;
            seq_q <= msl_pkg::SEQ_WAIT;
          end
        end
        msl_pkg::SEQ_WAIT: if (conv_rsp.done) seq_q <= msl_pkg::SEQ_CMP;
        msl_pkg::SEQ_CMP: seq_q <= msl_pkg::SEQ_NEXT;
        msl_pkg::SEQ_NEXT: begin
          ch_q <= ch_q + 3'h1;
          lp_cnt_q <= 10'h000;
          if (!run) begin
            seq_q <= msl_pkg::SEQ_IDLE;
          end else if (!last_ch || rate_q[msl_pkg::RATE_CONT_BIT]) begin
            seq_q <= msl_pkg::SEQ_START;
          end else begin
            seq_q <= msl_pkg::SEQ_PAUSE;
          end
        end
        msl_pkg::SEQ_PAUSE: begin
          if (!run) begin
            seq_q <= msl_pkg::SEQ_IDLE;
          end else if (tick && lp_done) begin
            seq_q <= msl_pkg::SEQ_START;
          end else if (tick) begin
            lp_cnt_q <= lp_cnt_q + 10'h001;
          end
        end
        default: seq_q <= msl_pkg::SEQ_IDLE;
      endcase
    end
  end

  assign conv_req = '{start: conv_start_q, chan: ch_q};

  // Per-channel result, limits and status
  for (genvar g = 0; g < msl_pkg::NCH; g++) begin : g_ch
    localparam logic [7:0] HI_ADDR = 8'(msl_pkg::REG_LIMIT_BASE + 2 * g);
    localparam logic [7:0] LO_ADDR = 8'(msl_pkg::REG_LIMIT_BASE + 2 * g + 1);
    localparam bit IS_TEMP = g == msl_pkg::TEMP_CH;
    logic viol;
    wire sel = ch_q == 3'(g);
    wire [7:0] v = res_hi[g];
    if (IS_TEMP) begin : g_temp
      assign res_hi[g] = res_q[g][msl_pkg::TEMP_W-1:1];
      assign res_lo[g] = {res_q[g][0], 7'h00};
      assign viol = ($signed(v) > $signed(lim_hi_q[g])) || ($signed(v) < $signed(lim_lo_q[g]));
    end else begin : g_volt
      assign res_hi[g] = res_q[g][msl_pkg::RES_W-1:4];
      assign res_lo[g] = {res_q[g][3:0], 4'h0};
      assign viol = (v > lim_hi_q[g]) || (v < lim_lo_q[g]);
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        res_q[g] <= '0;
        lim_hi_q[g] <= IS_TEMP ? msl_pkg::TEMP_HI_RST : msl_pkg::LIM_HI_RST;
        lim_lo_q[g] <= IS_TEMP ? msl_pkg::TEMP_LO_RST : msl_pkg::LIM_LO_RST;
        stat_q[g] <= 1'b0;
      end else begin
        if (sel && seq_q == msl_pkg::SEQ_WAIT && conv_rsp.done) res_q[g] <= conv_rsp.data;
        if (wr_en && ptr_q == HI_ADDR) lim_hi_q[g] <= sh_q;
        if (wr_en && ptr_q == LO_ADDR) lim_lo_q[g] <= sh_q;
        if (sel && seq_q == msl_pkg::SEQ_CMP && viol) begin
          stat_q[g] <= 1'b1;
        end else if (stat_clr) begin
          stat_q[g] <= 1'b0;
        end
      end
    end
  end

  // Alert output
  logic int_n_q;
  wire alert = cfg_q[msl_pkg::CFG_INT_EN_BIT] & |(stat_q & ~mask_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= ~alert;
    end
  end

  assign int_n = int_n_q;

endmodule : msl_core
`default_nettype wire

// ===== verif/msl_core_checker.sv
// Port-level checks of the monitor core, bound into msl_core.
// Assumes all channels stay enabled and the bus runs far slower than clk.
`timescale 1ns/1ps
`default_nettype none
module msl_core_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] addr_select_low,
  input wire logic [1:0] addr_select_high,
  input wire msl_pkg::msl_conv_req_t conv_req,
  input wire msl_pkg::msl_conv_rsp_t conv_rsp,
  input wire logic ext_ref_sel,
  input wire logic int_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic [2:0] last_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 3'h7;
    end else if (conv_req.start) begin
      last_q <= conv_req.chan;
    end
  end
  a_pin_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_start_one_pulse: assert property (conv_req.start |=> !conv_req.start)
    else $error("start longer than one cycle");
  a_done_start_gap: assert property (conv_rsp.done |=> !conv_req.start)
    else $error("start right after done");
  a_chan_in_order: assert property (conv_req.start |-> conv_req.chan == 3'(last_q + 3'h1))
    else $error("channel out of order");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data pin moved while clock high");
  a_reset_defaults: assert property ($rose(rstn) |-> !ext_ref_sel && int_n)
    else $error("bad state after reset");
  a_ref_by_bus: assert property ($changed(ext_ref_sel) |-> !scl_in)
    else $error("reference select moved off a bus write");
  a_alert_clear_bus: assert property ($rose(int_n) |-> !scl_in)
    else $error("alert released off a bus access");
  c_conv_done: cover property (conv_rsp.done);
  c_alert_low: cover property ($fell(int_n));
  c_ack_drive: cover property ($rose(sda_oe));
endmodule : msl_core_checker
bind msl_core msl_core_checker chk (
  .clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .addr_select_low(addr_select_low), .addr_select_high(addr_select_high),
  .conv_req(conv_req), .conv_rsp(conv_rsp), .ext_ref_sel(ext_ref_sel), .int_n(int_n)
);
`default_nettype wire

// ===== verif/msl_conv_model.sv
// Converter stand-in: answers each start after LAT cycles with the code in val.
// Assumes the bench fills val; the code is not held once done has passed.
`timescale 1ns/1ps
`default_nettype none
module msl_conv_model #(
  parameter int LAT = 6
) (
  input wire logic clk,
  input wire logic rstn,
  input wire msl_pkg::msl_conv_req_t conv_req,
  output var msl_pkg::msl_conv_rsp_t conv_rsp
);
  logic [11:0] val [8];
  logic [2:0] ch_q;
  int cnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 0;
      ch_q <= 3'h0;
      conv_rsp <= '0;
    end else begin
      conv_rsp.done <= 1'b0;
      conv_rsp.data <= ~conv_rsp.data;
      if (conv_req.start) begin
        cnt_q <= LAT;
        ch_q <= conv_req.chan;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
        if (cnt_q == 1) conv_rsp <= {1'b1, val[ch_q]};
      end
    end
  end
endmodule : msl_conv_model
`default_nettype wire

// ===== verif/tb_monitor_sequencer_limits.sv
// Self-checking bench: two-wire master tasks and one task per scenario.
// Assumes msl_conv_model on the converter port and a short timeout tick.
`timescale 1ns/1ps
`default_nettype none
module tb_monitor_sequencer_limits;
  // The timeout (26 ticks) must outlast the longest low run of a normal transfer, about 18 bit times
  localparam int TICKC = 100;
  localparam int QTR = 25;
  logic clk;
  logic rstn;
  logic scl_m;
  logic sda_m;
  logic [1:0] sel_lo;
  logic [1:0] sel_hi;
  logic sda_out;
  logic sda_oe;
  logic ext_ref_sel;
  logic int_n;
  msl_pkg::msl_conv_req_t conv_req;
  msl_pkg::msl_conv_rsp_t conv_rsp;
  wire logic sda_w;
  logic [6:0] dev_a;
  int fails;
  int n_tests;
  assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
  msl_core #(.TICK_CYCLES(TICKC)) dut (
    .clk(clk), .rstn(rstn), .scl_in(scl_m), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select_low(sel_lo), .addr_select_high(sel_hi),
    .conv_req(conv_req), .conv_rsp(conv_rsp), .ext_ref_sel(ext_ref_sel), .int_n(int_n)
  );
  msl_conv_model conv (.clk(clk), .rstn(rstn), .conv_req(conv_req), .conv_rsp(conv_rsp));
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic give_verdict;
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic q;
    repeat (QTR) @(posedge clk);
  endtask : q
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    q();
    scl_m <= 1'b1;
    q();
    r = sda_w;
    q();
    scl_m <= 1'b0;
    q();
  endtask : bit_io
  task automatic xfer(input logic [7:0] w, input logic m, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(m, a);
  endtask : xfer
  task automatic s_start;
    sda_m <= 1'b1;
    q();
    scl_m <= 1'b1;
    q();
    sda_m <= 1'b0;
    q();
    scl_m <= 1'b0;
    q();
  endtask : s_start
  task automatic s_stop;
    sda_m <= 1'b0;
    q();
    scl_m <= 1'b1;
    q();
    sda_m <= 1'b1;
    q();
  endtask : s_stop
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    logic [2:0] a;
    s_start();
    xfer({dev_a, 1'b0}, 1'b1, r, a[0]);
    xfer(p, 1'b1, r, a[1]);
    xfer(d, 1'b1, r, a[2]);
    s_stop();
    check({5'h00, a}, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic two, output logic [7:0] h, output logic [7:0] l);
    logic [7:0] r;
    logic [2:0] a;
    s_start();
    xfer({dev_a, 1'b0}, 1'b1, r, a[0]);
    xfer(p, 1'b1, r, a[1]);
    s_start();
    xfer({dev_a, 1'b1}, 1'b1, r, a[2]);
    xfer(8'hff, ~two, h, r[0]);
    l = 8'h00;
    if (two) xfer(8'hff, 1'b1, l, r[0]);
    s_stop();
    check({5'h00, a}, 8'h00);
  endtask : rd
  task automatic t_reset;
    logic [7:0] d;
    logic [7:0] x;
    check({7'h00, int_n}, 8'h01);
    rd(msl_pkg::REG_CONV_RATE, 1'b0, d, x);
    check(d, msl_pkg::RATE_RST);
    rd(msl_pkg::REG_ADV_CONFIG, 1'b0, d, x);
    check(d, msl_pkg::ADV_RST);
    rd(msl_pkg::REG_LIMIT_BASE, 1'b0, d, x);
    check(d, msl_pkg::LIM_HI_RST);
    rd(msl_pkg::REG_LIMIT_LAST, 1'b0, d, x);
    check(d, msl_pkg::TEMP_LO_RST);
  endtask : t_reset
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] x;
    logic a;
    wr(msl_pkg::REG_ADV_CONFIG, 8'h01);
    check({7'h00, ext_ref_sel}, 8'h01);
    s_start();
    xfer({dev_a, 1'b1}, 1'b1, x, a);
    xfer(8'hff, 1'b1, d, x[0]);
    s_stop();
    check(d, 8'h01);
    rd(8'h50, 1'b0, d, x);
    check(d, 8'h00);
    wr(msl_pkg::REG_ADV_CONFIG, 8'h00);
    check({7'h00, ext_ref_sel}, 8'h00);
  endtask : t_regs
  task automatic probe(input logic [6:0] ad, input logic e);
    logic [7:0] r;
    logic a;
    q();
    s_start();
    xfer({ad, 1'b0}, 1'b1, r, a);
    s_stop();
    check({7'h00, a}, {7'h00, e});
  endtask : probe
  task automatic t_addr;
    for (int h = 0; h < 3; h++) begin
      for (int l = 0; l < 3; l++) begin
        sel_hi <= 2'(h);
        sel_lo <= 2'(l);
        probe((h == 0 ? msl_pkg::ADDR_BASE_LOW : h == 1 ? msl_pkg::ADDR_BASE_MID
               : msl_pkg::ADDR_BASE_HIGH) + 7'(l), 1'b0);
      end
    end
    sel_hi <= msl_pkg::LVL_LOW;
    sel_lo <= msl_pkg::LVL_LOW;
    probe(msl_pkg::ADDR_BASE_LOW - 7'h01, 1'b1);
  endtask : t_addr
  task automatic t_seq;
    logic [7:0] d;
    logic [7:0] x;
    wr(msl_pkg::REG_LIMIT_BASE + 8'h04, 8'h10);
    wr(msl_pkg::REG_CONV_RATE, 8'h01);
    wr(msl_pkg::REG_CONFIG, 8'h03);
    repeat (300) @(posedge clk);
    check({7'h00, int_n}, 8'h00);
    rd(msl_pkg::REG_INT_STATUS, 1'b0, d, x);
    check(d, 8'h04);
    rd(msl_pkg::REG_RESULT_BASE + 8'h02, 1'b1, d, x);
    check(d, 8'h3a);
    check(x, 8'h50);
    rd(msl_pkg::REG_RESULT_BASE + 8'h07, 1'b1, d, x);
    check(d, 8'hf9);
    check(x, 8'h80);
    wr(msl_pkg::REG_INT_MASK, 8'h04);
    check({7'h00, int_n}, 8'h01);
    conv.val[2] <= 12'h0ab;
    repeat (300) @(posedge clk);
    rd(msl_pkg::REG_RESULT_BASE + 8'h02, 1'b1, d, x);
    check(d, 8'h0a);
    check(x, 8'hb0);
  endtask : t_seq
  // Clock held low mid-transfer; the next byte starts with data high, but the low clock line keeps the bus timeout counting
  task automatic t_hold(input int cyc, input logic e);
    logic [7:0] r;
    logic a;
    s_start();
    xfer({dev_a, 1'b0}, 1'b1, r, a);
    repeat (cyc) @(posedge clk);
    xfer(8'h8b, 1'b1, r, a);
    s_stop();
    check({7'h00, a}, {7'h00, e});
  endtask : t_hold
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial begin
    rstn = 1'b0;
    scl_m = 1'b1;
    sda_m = 1'b1;
    sel_lo = msl_pkg::LVL_LOW;
    sel_hi = msl_pkg::LVL_LOW;
    dev_a = msl_pkg::ADDR_BASE_LOW;
    fails = 0;
    n_tests = 0;
    for (int i = 0; i < 8; i++) conv.val[i] = 12'h000;
    conv.val[2] = 12'h3a5;
    conv.val[7] = 12'h1f3;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    t_reset();
    t_regs();
    t_addr();
    t_seq();
    t_hold(20 * TICKC, 1'b0);
    t_hold(40 * TICKC, 1'b1);
    give_verdict();
  end
endmodule : tb_monitor_sequencer_limits
`default_nettype wire
